// ### logic/isf_fault_resp.v
`timescale 1ns/1ps
`default_nettype none
`include "isf_map.vh"

module isf_fault_resp (
    // clock and reset
    input  wire        ref_clk,
    input  wire        srst,
    // comparator levels, active high fault
    input  wire        pump_high_over,
    input  wire        pump_low_under,
    input  wire        pump_low_over,
    input  wire        monitor_supply_under,
    input  wire        monitor_supply_over,
    input  wire        analog_supply_under,
    input  wire        digital_supply_under,
    input  wire        digital_supply_over,
    input  wire        bandgap_mon_above,
    input  wire        bandgap_mon_below,
    // status readout and clear
    input  wire        status_clear,
    output reg  [7:0]  supply_monitor_status_one_q,
    // diagnostic mux
    input  wire [3:0]  diagnostic_mux_sel,
    output reg         diagnostic_mux_q,
    // device outputs
    output reg         mcu_reset_out_n_q,
    output reg         safing_drive_enable_q,
    output reg         internal_power_on_reset_n_q,
    output reg         standby_q,
    output reg         rails_operational_q
);
    // ------------------------------------------------------------------
    // filtered fault levels
    // ------------------------------------------------------------------
    // index order of raw fixes which filter serves which comparator
    localparam NF = 10;
    wire [NF-1:0] raw = {bandgap_mon_below, bandgap_mon_above,
                         digital_supply_over, digital_supply_under,
                         analog_supply_under, monitor_supply_over,
                         monitor_supply_under, pump_low_over,
                         pump_low_under, pump_high_over};
    wire [NF-1:0] flt;

    // one filter per comparator; they hold the deglitch time, and a
    // shared filter would let one fault mask the timing of another
    genvar gi;
    generate
        for (gi = 0; gi < NF; gi = gi + 1) begin : g_flt
            isf_deglitch #(
                .CYCLES (`ISF_DEGLITCH_CYC)
            ) u_dg (
                .ref_clk (ref_clk),
                .srst    (srst),
                .raw_in  (raw[gi]),
                .filt_q  (flt[gi])
            );
        end
    endgenerate

    // filtered levels by source; under and over of the monitor and digital supplies merge
    wire f_hi_ov   = flt[0];
    wire f_lo_uv   = flt[1];
    wire f_lo_ov   = flt[2];
    wire f_mon     = flt[3] | flt[4];
    wire f_ana_uv  = flt[5];
    wire f_dig     = flt[6] | flt[7];
    // reference cross-check: monitor reference above or below main
    wire f_bg_high = flt[8];
    wire f_bg_low  = flt[9];

    // ------------------------------------------------------------------
    // fault classification
    // ------------------------------------------------------------------
    // faults that also pull the internal power-on reset low
    wire por_fault = f_mon | f_ana_uv | f_dig;
    // every fault that ends in standby; the pump low rail undervoltage
    // is left out on purpose, it only ever sets its status bit
    wire stb_fault = f_hi_ov | f_lo_ov | f_bg_high | f_bg_low
                   | por_fault;

    // mux position decode, shared by readout
    function mux_pick;
        input [3:0] sel;
        input [7:0] v;
        begin
            case (sel)
                `ISF_MUX_ANA_UV_N:     mux_pick = v[0];
                `ISF_MUX_BG_HIGH:      mux_pick = v[1];
                `ISF_MUX_BG_LOW:       mux_pick = v[2];
                `ISF_MUX_PUMP_LO_UV_N: mux_pick = v[3];
                `ISF_MUX_PUMP_LO_OV:   mux_pick = v[4];
                `ISF_MUX_PUMP_HI_OV:   mux_pick = v[5];
                default:               mux_pick = 1'b0;
            endcase
        end
    endfunction

    // mux source vector; the active-low comparator names read inverted,
    // so a healthy supply shows a one at its position
    reg  [7:0] mux_vec;
    always @* begin
        mux_vec    = 8'h00;
        mux_vec[0] = ~f_ana_uv;
        mux_vec[1] = f_bg_high;
        mux_vec[2] = f_bg_low;
        mux_vec[3] = ~f_lo_uv;
        mux_vec[4] = f_lo_ov;
        mux_vec[5] = f_hi_ov;
    end

    // ------------------------------------------------------------------
    // status flags: sticky, set beats clear
    // ------------------------------------------------------------------
    // per-flag set terms, taken straight from the filtered levels
    reg  [7:0] set_bits;
    always @* begin
        set_bits = 8'h00;
        set_bits[`ISF_STAT_PUMP_HI_OV] = f_hi_ov;
        set_bits[`ISF_STAT_PUMP_LO_UV] = f_lo_uv;
        set_bits[`ISF_STAT_PUMP_LO_OV] = f_lo_ov;
        set_bits[`ISF_STAT_MON_SUPPLY] = f_mon;
    end

    // a clear reloads only this cycle's set terms, so a fault that is
    // still standing survives the clear instead of being lost
    always @(posedge ref_clk) begin
        if (srst) begin
            supply_monitor_status_one_q <= `ISF_STAT_RESET;
        end else if (status_clear) begin
            supply_monitor_status_one_q <= set_bits;
        end else begin
            supply_monitor_status_one_q <= supply_monitor_status_one_q
                                         | set_bits;
        end
    end

    // ------------------------------------------------------------------
    // device state; standby only leaves through power-on reset
    // ------------------------------------------------------------------
    // binary state codes, one bit is enough for two states
    localparam ST_ACTIVE  = 1'b0;
    localparam ST_STANDBY = 1'b1;

    reg        standby_d;

    // next state: any standby-class fault latches standby for good;
    // nothing in this block can bring the device back to active
    always @* begin
        standby_d = standby_q;
        case (standby_q)
            // active: wait for a filtered standby-class fault
            ST_ACTIVE: begin
                if (stb_fault) begin
                    standby_d = ST_STANDBY;
                end
            end
            // standby: held, only srst from a new power-up leaves it
            ST_STANDBY: begin
                standby_d = ST_STANDBY;
            end
            // unreachable with one bit, but fail safe
            default: begin
                standby_d = ST_STANDBY;
            end
        endcase
    end

    // state register
    always @(posedge ref_clk) begin
        if (srst) begin
            standby_q <= ST_ACTIVE;
        end else begin
            standby_q <= standby_d;
        end
    end

    // reset and drive enable fall on the same edge that enters standby,
    // so the mcu never sees a cycle of standby with its drive still on
    always @(posedge ref_clk) begin
        if (srst) begin
            mcu_reset_out_n_q     <= 1'b1;
            safing_drive_enable_q <= 1'b1;
        end else begin
            mcu_reset_out_n_q     <= (standby_d == ST_ACTIVE);
            safing_drive_enable_q <= (standby_d == ST_ACTIVE);
        end
    end

    // power-on reset follows the filtered levels and is not sticky;
    // standby is what keeps the outputs down once the fault clears
    always @(posedge ref_clk) begin
        if (srst) begin
            internal_power_on_reset_n_q <= 1'b1;
        end else begin
            internal_power_on_reset_n_q <= ~por_fault;
        end
    end

    // one flag stands for the can, io and core rails; it drops on a
    // pump low rail overvoltage and only srst raises it again
    always @(posedge ref_clk) begin
        if (srst) begin
            rails_operational_q <= 1'b1;
        end else if (f_lo_ov) begin
            rails_operational_q <= 1'b0;
        end
    end

    // registered mux readout, one cycle behind the select; the extra
    // cycle keeps the output pin straight off a flip-flop
    always @(posedge ref_clk) begin
        if (srst) begin
            diagnostic_mux_q <= 1'b0;
        end else begin
            diagnostic_mux_q <= mux_pick(diagnostic_mux_sel, mux_vec);
        end
    end
endmodule
`default_nettype wire

// ### logic/isf_map.vh
`ifndef ISF_MAP_VH
`define ISF_MAP_VH
// status register bit positions
`define ISF_STAT_MON_SUPPLY   2
`define ISF_STAT_PUMP_LO_UV   3
`define ISF_STAT_PUMP_LO_OV   4
`define ISF_STAT_PUMP_HI_OV   5
`define ISF_STAT_RESET        8'h00
// deglitch window in ns and derived cycles at 250 MHz
`define ISF_CLK_PERIOD_NS     4
`define ISF_DEGLITCH_MIN_NS   15000
`define ISF_DEGLITCH_MAX_NS   30000
`define ISF_DEGLITCH_CYC      ((`ISF_DEGLITCH_MIN_NS + `ISF_CLK_PERIOD_NS - 1) / `ISF_CLK_PERIOD_NS)
// diagnostic mux positions (group 1)
`define ISF_MUX_ANA_UV_N      4'h2
`define ISF_MUX_BG_HIGH       4'h3
`define ISF_MUX_BG_LOW        4'h4
`define ISF_MUX_PUMP_LO_UV_N  4'h5
`define ISF_MUX_PUMP_LO_OV    4'h6
`define ISF_MUX_PUMP_HI_OV    4'h7
// device states
`define ISF_ST_ACTIVE         1'b0
`define ISF_ST_STANDBY        1'b1
`endif

// ### logic/isf_deglitch.v
`timescale 1ns/1ps
`default_nettype none
`include "isf_map.vh"

// deglitch filter: input synchronised through three flops, then a change
// is accepted only when it has stood for the full deglitch count
module isf_deglitch #(
    parameter CYCLES = 3750
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        srst,
    // raw comparator level and filtered level
    input  wire        raw_in,
    output reg         filt_q
);
    reg  [2:0]  sync_q;
    reg  [15:0] cnt_q;
    wire        stable = (sync_q[1] == sync_q[2]);

    // three-stage synchroniser, stage 0 feeds only stage 1
    always @(posedge ref_clk) begin
        if (srst) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], raw_in};
        end
    end

    // count while the settled level differs from the filtered output;
    // any bounce restarts the count so short glitches never pass
    always @(posedge ref_clk) begin
        if (srst) begin
            cnt_q  <= 16'h0000;
            filt_q <= 1'b0;
        end else if (!stable || sync_q[2] == filt_q) begin
            cnt_q <= 16'h0000;
        end else if (cnt_q == CYCLES[15:0] - 16'h0001) begin
            cnt_q  <= 16'h0000;
            filt_q <= sync_q[2];
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ### testbench/isf_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------
// external mcu partner
// --------------------
module isf_mcu_model (
    // clock and device outputs
    input  wire logic ref_clk,
    input  wire logic mcu_reset_out_n,
    input  wire logic safing_drive_enable,
    // mcu runs only out of reset with its drive path enabled
    output var  logic mcu_running_q
);
    // registered like a real mcu input stage
    always_ff @(posedge ref_clk) begin
        mcu_running_q <= mcu_reset_out_n && safing_drive_enable;
    end
endmodule
`default_nettype wire

// ### testbench/isf_fault_resp_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------
// fault response checks
// ---------------------
module isf_fault_resp_chk (
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic       pump_high_over,
    input wire logic [7:0] supply_monitor_status_one_q,
    input wire logic       mcu_reset_out_n_q,
    input wire logic       safing_drive_enable_q,
    input wire logic       internal_power_on_reset_n_q,
    input wire logic       standby_q
);
    logic [15:0] hi_cnt_q;
    // raw high-rail fault run length, max run stays far below wrap
    always_ff @(posedge ref_clk) begin
        hi_cnt_q <= (srst || !pump_high_over) ? 16'h0 : hi_cnt_q + 16'h1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    stby_hold_a: assert property (standby_q |=> standby_q)
        else $error("standby left without reset");
    outs_low_a: assert property (standby_q |->
        !mcu_reset_out_n_q && !safing_drive_enable_q)
        else $error("standby with outputs high");
    uv_only_a: assert property ($rose(supply_monitor_status_one_q[3]) |->
        ##1 $stable(mcu_reset_out_n_q) && !standby_q)
        else $error("low rail undervoltage changed state");
    filt_time_a: assert property ($rose(supply_monitor_status_one_q[5]) |->
        hi_cnt_q >= 16'hEA6 && hi_cnt_q <= 16'h1D4C)
        else $error("deglitch time out of window");
    hi_ov_a: assert property ($rose(supply_monitor_status_one_q[5]) |->
        ##[0:2] standby_q)
        else $error("high rail fault without standby");
    por_stby_a: assert property ($fell(internal_power_on_reset_n_q) |->
        ##[0:2] standby_q)
        else $error("power-on reset without standby");
    mon_a: assert property ($rose(supply_monitor_status_one_q[2]) |->
        ##[0:2] (!internal_power_on_reset_n_q && standby_q))
        else $error("monitor supply fault response missing");
    lo_ov_a: assert property ($rose(supply_monitor_status_one_q[4]) |->
        ##[0:2] standby_q)
        else $error("low rail overvoltage without standby");
    cover property ($rose(standby_q));
    cover property ($rose(supply_monitor_status_one_q[3]));
    cover property ($fell(internal_power_on_reset_n_q));
endmodule
bind isf_fault_resp isf_fault_resp_chk u_chk (
    .ref_clk(ref_clk), .srst(srst), .pump_high_over(pump_high_over),
    .supply_monitor_status_one_q(supply_monitor_status_one_q),
    .mcu_reset_out_n_q(mcu_reset_out_n_q),
    .safing_drive_enable_q(safing_drive_enable_q),
    .internal_power_on_reset_n_q(internal_power_on_reset_n_q),
    .standby_q(standby_q));
`default_nettype wire

// ### testbench/isf_fault_resp_tb.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------
// fault response tb
// -----------------
module isf_fault_resp_tb;
    logic ref_clk, srst;
    logic [9:0] flt;
    logic [3:0] sel;
    logic clr;
    logic [15:0] rs;
    wire logic [7:0] st;
    wire logic mq, rn, dr, pn, sb, rl, run;
    int err_total, total_checks, cyc, n;
    initial begin
        ref_clk = 0;
        forever #2 ref_clk = ~ref_clk;
    end
    isf_fault_resp dut (.ref_clk(ref_clk), .srst(srst),
        .pump_high_over(flt[0]), .pump_low_under(flt[1]),
        .pump_low_over(flt[2]), .monitor_supply_under(flt[3]),
        .monitor_supply_over(flt[4]), .analog_supply_under(flt[5]),
        .digital_supply_under(flt[6]), .digital_supply_over(flt[7]),
        .bandgap_mon_above(flt[8]), .bandgap_mon_below(flt[9]),
        .status_clear(clr), .supply_monitor_status_one_q(st),
        .diagnostic_mux_sel(sel), .diagnostic_mux_q(mq),
        .mcu_reset_out_n_q(rn), .safing_drive_enable_q(dr),
        .internal_power_on_reset_n_q(pn), .standby_q(sb),
        .rails_operational_q(rl));
    isf_mcu_model u_mcu (.ref_clk(ref_clk), .mcu_reset_out_n(rn),
        .safing_drive_enable(dr), .mcu_running_q(run));
    function automatic logic [15:0] xs(input logic [15:0] s);
        s ^= s << 7;
        s ^= s >> 9;
        return s ^ (s << 8);
    endfunction
    // status bit per fault index, as ordered on flt
    function automatic logic [7:0] ex_st(input int i);
        return i == 0 ? 8'h20 : i == 1 ? 8'h08 : i == 2 ? 8'h10 :
               (i == 3 || i == 4) ? 8'h04 : 8'h00;
    endfunction
    function automatic logic [3:0] ex_pos(input int i);
        return i == 0 ? 4'h7 : i == 1 ? 4'h5 : i == 2 ? 4'h6 :
               i == 5 ? 4'h2 : i == 8 ? 4'h3 : i == 9 ? 4'h4 : 4'h0;
    endfunction
    task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // inputs move 1 ns after the edge, never on it
    task tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // whole run needs about 78k cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 90000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        rs = 16'd11494;
        srst = 1;
        flt = 0;
        sel = 0;
        clr = 0;
        tick(3);
        srst = 0;
        rs = xs(rs);
        flt[rs % 10] = 1;
        tick(100 + rs % 3000);
        flt = 0;
        tick(20);
        chk(st, 8'h00, "glitch status");
        chk({4'h0, sb, rn, dr, pn}, 8'h07, "glitch state");
        for (int i = 0; i < 10; i++) begin
            srst = 1;
            tick(1);
            srst = 0;
            flt[i] = 1;
            n = 0;
            while (!sb && st == 0 && n < 8000) begin
                tick(1);
                n++;
            end
            chk(8'(n >= 3750 && n <= 7500), 8'h01, "delay");
            tick(2);
            chk(st, ex_st(i), "status");
            chk({4'h0, sb, rn, dr, pn}, {4'h0, i != 1, i == 1, i == 1,
                !(i >= 3 && i <= 7)}, "state");
            chk({7'h0, rl}, {7'h0, i != 2}, "rails");
            // clear while the fault still stands: the set term must win
            clr = 1;
            tick(1);
            clr = 0;
            chk(st, ex_st(i), "clear vs set");
            sel = ex_pos(i);
            tick(3);
            chk({7'h0, mq}, {7'h0, !(sel inside {0, 2, 5})}, "mux");
            flt = 0;
            rs = xs(rs);
            sel = rs[3:0];
            // wait out the falling deglitch so the filters read healthy
            tick(3800);
            chk({6'h0, rn, run}, {6'h0, i == 1, i == 1}, "hold");
            chk({6'h0, sb, pn}, {6'h0, i != 1, 1'b1}, "standby");
            chk(st, ex_st(i), "sticky");
            chk({7'h0, mq}, {7'h0, sel inside {2, 5}}, "idle mux");
            // clear once the fault is gone: every flag must drop
            clr = 1;
            tick(1);
            clr = 0;
            chk(st, 8'h00, "cleared");
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
